/* File: common/dp_pkg.sv */
// Shared types and constants of the dual-MAC compute datapath
//
// Contract
// - Eight 32-bit general compute registers.
// - Sixteen 16-bit halves addressable independently.
// - Operands only from registers or immediate.
// - Units handle 8, 16, 32-bit data.
// - Two MACs, 16x16 each cycle, 40-bit accumulate.
// - Signed/unsigned MAC, selectable rounding, saturation.
// - ALU arithmetic/logic on 16 or 32 bits.
// - Extract, popcount, mul32, divide step, sat, round, signbits.
// - Byte align/pack, clipped adds, average, sub-abs-accumulate.
// - Compare-select and vector search operations.
// - Dual 16-bit ops on high and low halves.
// - Second ALU gives quad 16-bit ops.
// - 40-bit shift, rotate, normalize, extract, deposit.
// - Two addresses generated in one cycle.
// - Four circular index/modify/length/base sets.
// - Eight pointer registers for stack/frame addressing.
// - Hardware interlock on data dependencies.
`default_nettype none
package dp_pkg;
  localparam int NUM_REGS = 8;
  localparam int NUM_SETS = 4;
  localparam int NUM_PTRS = 8;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
  localparam logic [39:0] ACC_MAX = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] ACC_MIN = 40'h80_0000_0000;
  localparam logic [39:0] RND_HALF = 40'h00_0000_8000;
  localparam logic [31:0] W_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] W_MIN = 32'h8000_0000;
  localparam logic [15:0] H_MAX = 16'h7FFF;
  localparam logic [15:0] H_MIN = 16'h8000;
  localparam logic [7:0] B_MAX = 8'hFF;
  localparam logic [5:0] ROT_SPAN = 6'h28;
  localparam logic [1:0] MASK_ALL = 2'h3;
  typedef enum logic [1:0] {W8, W16, W32} width_e;
  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOT, OP_DUAL, OP_QUAD,
    OP_EXTR, OP_POPC, OP_MUL32, OP_DIVS, OP_SAT, OP_RND, OP_SIGNB, OP_ALIGN8,
    OP_PACK, OP_ADDC16, OP_ADDC8, OP_AVG8, OP_SUB_ABS_ACC, OP_MIN, OP_MAX, OP_VSRCH,
    OP_SHL, OP_SHR, OP_ROT, OP_NORM, OP_DEPO, OP_MACRD0, OP_MACRD1
  } alu_op_e;
  typedef enum logic [2:0] {AG_IDX, AG_MOD, AG_LEN, AG_BASE, AG_PTR} ag_kind_e;
endpackage
`default_nettype wire

/* File: common/dp_if.sv */
// Carriers between the datapath top and its MAC and address units
`default_nettype none
interface mac_if;
  logic en;
  logic clr;
  logic sgn;
  logic rnd;
  logic sat;
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [39:0] acc;
  logic [31:0] rd;
  modport ctl (output en, clr, sgn, rnd, sat, op_a, op_b, input acc, rd);
  modport unit (input en, clr, sgn, rnd, sat, op_a, op_b, output acc, rd);
endinterface

interface agu_if;
  logic wr_en;
  dp_pkg::ag_kind_e wr_kind;
  logic [2:0] wr_num;
  logic [31:0] wr_data;
  logic [1:0] gen_en;
  logic [1:0] circ;
  logic [2:0] sel [2];
  logic [31:0] off;
  logic [31:0] addr [2];
  logic [1:0] valid;
  modport ctl (output wr_en, wr_kind, wr_num, wr_data, gen_en, circ, sel, off, input addr, valid);
  modport unit (input wr_en, wr_kind, wr_num, wr_data, gen_en, circ, sel, off, output addr, valid);
endinterface
`default_nettype wire

/* File: hw/mac_unit.sv */
// One 16x16 multiply-accumulate unit with a 40-bit accumulator
`default_nettype none
module mac_unit (
  input wire logic clk_sys,
  input wire logic rst,
  mac_if.unit m
);
  import dp_pkg::*;
  logic [16:0] pa, pb;
  logic [33:0] prod;
  logic [39:0] base;
  logic [40:0] sum;
  logic [39:0] next_acc;
  logic [39:0] rnd_acc;

  // Unsigned operands get a zero sign bit so one signed multiplier serves both
  assign pa = {m.sgn & m.op_a[15], m.op_a};
  assign pb = {m.sgn & m.op_b[15], m.op_b};
  assign prod = 34'($signed(pa) * $signed(pb));
  assign base = m.clr ? ACC_RST : m.acc;
  assign sum = {base[39], base} + {{7{prod[33]}}, prod};

  // Overflow shows as disagreement of the two top sum bits
  always_comb begin
    next_acc = sum[39:0];
    if (m.sat && (sum[40] != sum[39])) begin
      next_acc = sum[40] ? ACC_MIN : ACC_MAX;
    end
  end

  // Accumulator only moves on an enabled cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      m.acc <= ACC_RST;
    end else if (m.en) begin
      m.acc <= next_acc;
    end
  end

  // Read-out: optional round to the high half, then optional clamp to 32 bits
  assign rnd_acc = m.rnd ? m.acc + RND_HALF : m.acc;
  always_comb begin
    m.rd = m.rnd ? {rnd_acc[31:16], 16'h0000} : rnd_acc[31:0];
    if (m.sat && (rnd_acc[39:31] != {9{rnd_acc[39]}})) begin
      m.rd = rnd_acc[39] ? W_MIN : W_MAX;
    end
  end
endmodule
`default_nettype wire

/* File: hw/addr_gen_unit.sv */
// Dual address generator with circular-buffer and pointer registers
`default_nettype none
module addr_gen_unit #(
  parameter int NSETS = dp_pkg::NUM_SETS,
  parameter int NPTRS = dp_pkg::NUM_PTRS
) (
  input wire logic clk_sys,
  input wire logic rst,
  agu_if.unit ag
);
  import dp_pkg::*;
  logic [31:0] idx [NSETS];
  logic [31:0] mdf [NSETS];
  logic [31:0] len [NSETS];
  logic [31:0] base [NSETS];
  logic [31:0] ptr [NPTRS];
  logic [31:0] cur [2];
  logic [31:0] nxt [2];

  // Both channels are computed side by side so two fetches share a cycle
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [1:0] s;
    logic [31:0] step;
    logic [31:0] lim;
    assign s = ag.sel[c][1:0];
    assign cur[c] = ag.circ[c] ? idx[s] : ptr[ag.sel[c]] + ag.off;
    assign step = idx[s] + mdf[s];
    assign lim = base[s] + len[s];
    // Zero length means plain linear post-modify
    always_comb begin
      nxt[c] = step;
      if (len[s] != '0 && step >= lim) begin
        nxt[c] = step - len[s];
      end else if (len[s] != '0 && step < base[s]) begin
        nxt[c] = step + len[s];
      end
    end
  end

  // Register writes; channel 1 update wins over channel 0, both over a write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int k = 0; k < NSETS; k++) begin
        idx[k] <= REG_RST;
        mdf[k] <= REG_RST;
        len[k] <= REG_RST;
        base[k] <= REG_RST;
      end
      for (int k = 0; k < NPTRS; k++) begin
        ptr[k] <= REG_RST;
      end
    end else begin
      if (ag.wr_en) begin
        unique case (ag.wr_kind)
          AG_IDX: idx[ag.wr_num[1:0]] <= ag.wr_data;
          AG_MOD: mdf[ag.wr_num[1:0]] <= ag.wr_data;
          AG_LEN: len[ag.wr_num[1:0]] <= ag.wr_data;
          AG_BASE: base[ag.wr_num[1:0]] <= ag.wr_data;
          AG_PTR: ptr[ag.wr_num] <= ag.wr_data;
          default: ;
        endcase
      end
      for (int c = 0; c < 2; c++) begin
        if (ag.gen_en[c] && ag.circ[c]) begin
          idx[ag.sel[c][1:0]] <= nxt[c];
        end
      end
    end
  end

  // Addresses leave from flops, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ag.addr[0] <= REG_RST;
      ag.addr[1] <= REG_RST;
      ag.valid <= 2'h0;
    end else begin
      ag.addr[0] <= cur[0];
      ag.addr[1] <= cur[1];
      ag.valid <= ag.gen_en;
    end
  end
endmodule
`default_nettype wire

/* File: hw/dual_mac_compute_datapath.sv */
// Top of the dual-MAC compute datapath: registers, ALUs, shifter, MACs, AGU
`default_nettype none
module dual_mac_compute_datapath (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic issue,
  input wire dp_pkg::alu_op_e alu_op,
  input wire dp_pkg::width_e width,
  input wire logic [3:0] src_a,
  input wire logic [3:0] src_b,
  input wire logic use_imm,
  input wire logic [31:0] imm,
  input wire logic wr_en,
  input wire logic [2:0] dst,
  input wire logic [1:0] dst_mask,
  input wire logic [2:0] dst2,
  input wire logic [1:0] mac_en,
  input wire logic mac_clr,
  input wire logic mac_sgn,
  input wire logic mac_rnd,
  input wire logic mac_sat,
  input wire logic ld_en,
  input wire logic [2:0] ld_dst,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic ag_wr_en,
  input wire dp_pkg::ag_kind_e ag_wr_kind,
  input wire logic [2:0] ag_wr_num,
  input wire logic [31:0] ag_wr_data,
  input wire logic [1:0] ag_en,
  input wire logic [1:0] ag_circ,
  input wire logic [2:0] ag_sel0,
  input wire logic [2:0] ag_sel1,
  output logic stall,
  output logic res_valid,
  output logic [31:0] res,
  output logic [7:0] res_ext,
  output logic [1:0] cc,
  output logic [39:0] acc0,
  output logic [39:0] acc1,
  output logic [31:0] addr0,
  output logic [31:0] addr1,
  output logic [1:0] addr_valid
);
  import dp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0] rf [NUM_REGS];
  logic take;
  logic [2:0] ld_tag;
  logic wb_valid;
  logic [2:0] wb_dst;
  logic [1:0] wb_mask;
  logic [31:0] wb_data;
  logic wb2_valid;
  logic [2:0] wb2_dst;
  logic [31:0] wb2_data;
  logic [31:0] ra, rb, rd_v;
  logic [31:0] a_op, b_op;
  logic [15:0] a16, b16;
  logic [31:0] add8_v, sub8_v, clip8_v, avg8_v, absd_v;
  logic [31:0] dadd_v, dsub_v, clip16_v, vmax_v;
  logic [1:0] vsel;
  logic [31:0] add_w, sub_w;
  logic [15:0] s16a, s16s;
  logic [63:0] mul_v;
  logic [31:0] divs_v;
  logic [16:0] div_t;
  logic [15:0] sat16, rnd16;
  logic [16:0] rnd_t;
  logic [4:0] signb;
  logic [31:0] fmask, dmask, extr_v, depo_v;
  logic [31:0] align_v, pack_v;
  logic [15:0] abs_sum_lo, abs_sum_hi;
  logic [39:0] ext40, sh_l, sh_r, sh_rot;
  logic [5:0] amt, rot_n;
  logic [31:0] alu_res;
  logic [7:0] alu_ext;
  logic [1:0] alu_cc;
  logic cc_upd;

  mac_if m0 ();
  mac_if m1 ();
  agu_if ag ();

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // Overlay a pending write-back onto a register value, half by half
  function automatic logic [31:0] merge(input logic [31:0] old, input logic hit,
                                        input logic [1:0] m, input logic [31:0] d);
    merge = old;
    if (hit && m[0]) begin
      merge[15:0] = d[15:0];
    end
    if (hit && m[1]) begin
      merge[31:16] = d[31:16];
    end
  endfunction

  // Redundant sign bits below the sign, the exponent of a fraction
  function automatic logic [4:0] sign_bits(input logic [31:0] v);
    logic done;
    done = 1'b0;
    sign_bits = 5'h00;
    for (int k = 30; k >= 0; k--) begin
      if (!done && v[k] == v[31]) begin
        sign_bits = sign_bits + 5'h01;
      end else begin
        done = 1'b1;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Issue and interlock

  // An issue is taken only while no load is outstanding
  assign take = issue && !stall;

  // Stall rises after a load issues and falls with the returning data; the
  // data is written on that same edge, so the next issue reads it safely
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stall <= 1'b0;
      ld_tag <= 3'h0;
    end else if (take && ld_en) begin
      stall <= 1'b1;
      ld_tag <= ld_dst;
    end else if (mem_rvalid) begin
      stall <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file and operand fetch

  // Load data first, then compute results, so a newer result wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int k = 0; k < NUM_REGS; k++) begin
        rf[k] <= REG_RST;
      end
    end else begin
      if (mem_rvalid && stall) begin
        rf[ld_tag] <= mem_rdata;
      end
      if (wb_valid && wb_mask[0]) begin
        rf[wb_dst][15:0] <= wb_data[15:0];
      end
      if (wb_valid && wb_mask[1]) begin
        rf[wb_dst][31:16] <= wb_data[31:16];
      end
      if (wb2_valid) begin
        rf[wb2_dst] <= wb2_data;
      end
    end
  end

  // Three read ports with bypass from the write-back stage
  always_comb begin
    ra = merge(rf[src_a[3:1]], wb_valid && wb_dst == src_a[3:1], wb_mask, wb_data);
    ra = merge(ra, wb2_valid && wb2_dst == src_a[3:1], MASK_ALL, wb2_data);
    rb = merge(rf[src_b[3:1]], wb_valid && wb_dst == src_b[3:1], wb_mask, wb_data);
    rb = merge(rb, wb2_valid && wb2_dst == src_b[3:1], MASK_ALL, wb2_data);
    rd_v = merge(rf[dst], wb_valid && wb_dst == dst, wb_mask, wb_data);
    rd_v = merge(rd_v, wb2_valid && wb2_dst == dst, MASK_ALL, wb2_data);
  end

  // Second operand is a register or the instruction constant, nothing else
  assign a_op = ra;
  assign b_op = use_imm ? imm : rb;
  assign a16 = src_a[0] ? ra[31:16] : ra[15:0];
  assign b16 = use_imm ? imm[15:0] : (src_b[0] ? rb[31:16] : rb[15:0]);

  //////////////////////////////////////////////////////////////////////////
  // Byte lanes: four video ALUs
  for (genvar i = 0; i < 4; i++) begin : g_byte
    logic [7:0] ab, bb;
    logic [8:0] s9, s9r;
    assign ab = a_op[8*i+:8];
    assign bb = b_op[8*i+:8];
    assign s9 = {1'b0, ab} + {1'b0, bb};
    assign s9r = s9 + 9'h001;
    assign add8_v[8*i+:8] = ab + bb;
    assign sub8_v[8*i+:8] = ab - bb;
    assign clip8_v[8*i+:8] = s9[8] ? B_MAX : s9[7:0];
    assign avg8_v[8*i+:8] = s9r[8:1];
    assign absd_v[8*i+:8] = (ab >= bb) ? ab - bb : bb - ab;
  end

  //////////////////////////////////////////////////////////////////////////
  // Half lanes: dual 16-bit operations on high and low halves
  for (genvar j = 0; j < 2; j++) begin : g_half
    logic [15:0] ah, bh;
    logic [16:0] s17;
    assign ah = a_op[16*j+:16];
    assign bh = b_op[16*j+:16];
    assign s17 = {ah[15], ah} + {bh[15], bh};
    assign dadd_v[16*j+:16] = ah + bh;
    assign dsub_v[16*j+:16] = ah - bh;
    assign clip16_v[16*j+:16] = (s17[16] != s17[15]) ? (s17[16] ? H_MIN : H_MAX) : s17[15:0];
    assign vsel[j] = $signed(bh) > $signed(ah);
    assign vmax_v[16*j+:16] = vsel[j] ? bh : ah;
  end

  //////////////////////////////////////////////////////////////////////////
  // Width-steered add and subtract
  assign s16a = a16 + b16;
  assign s16s = a16 - b16;
  always_comb begin
    unique case (width)
      W8: begin
        add_w = add8_v;
        sub_w = sub8_v;
      end
      W16: begin
        add_w = {{16{s16a[15]}}, s16a};
        sub_w = {{16{s16s[15]}}, s16s};
      end
      default: begin
        add_w = a_op + b_op;
        sub_w = a_op - b_op;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Special ALU primitives
  assign mul_v = a_op * b_op;
  // One restoring divide step: shift left, trial-subtract divisor
  assign div_t = {1'b0, a_op[30:15]} - {1'b0, b_op[15:0]};
  assign divs_v = div_t[16] ? {a_op[30:0], 1'b0} : {div_t[15:0], a_op[14:0], 1'b1};
  assign sat16 = (a_op[31:15] == {17{a_op[31]}}) ? a_op[15:0] : (a_op[31] ? H_MIN : H_MAX);
  assign rnd_t = {a_op[31], a_op[31:16]} + {16'h0000, a_op[15]};
  assign rnd16 = (rnd_t[16] != rnd_t[15]) ? H_MAX : rnd_t[15:0];
  assign signb = sign_bits(a_op);
  // Field spec in operand b: length in bits 4:0, position in bits 12:8
  assign fmask = ~(32'hFFFF_FFFF << b_op[4:0]);
  assign extr_v = (a_op >> b_op[12:8]) & fmask;
  assign dmask = fmask << b_op[12:8];
  assign depo_v = (a_op & ~dmask) | (({16'h0000, b_op[31:16]} << b_op[12:8]) & dmask);
  assign align_v = 32'({a_op, b_op} >> {imm[1:0], 3'h0});
  assign pack_v = {a_op[23:16], a_op[7:0], b_op[23:16], b_op[7:0]};
  assign abs_sum_lo = 16'(absd_v[7:0]) + 16'(absd_v[15:8]);
  assign abs_sum_hi = 16'(absd_v[23:16]) + 16'(absd_v[31:24]);

  //////////////////////////////////////////////////////////////////////////
  // 40-bit shifter; rotate counts fold into the 40-bit span
  assign ext40 = {{8{a_op[31]}}, a_op};
  assign amt = b_op[5:0];
  assign rot_n = (amt >= ROT_SPAN) ? amt - ROT_SPAN : amt;
  assign sh_l = ext40 << amt;
  assign sh_r = 40'($signed(ext40) >>> amt);
  assign sh_rot = (ext40 << rot_n) | (ext40 >> (ROT_SPAN - rot_n));

  //////////////////////////////////////////////////////////////////////////
  // MAC units: MAC0 takes the selected halves, MAC1 the high halves
  assign m0.en = take && mac_en[0];
  assign m1.en = take && mac_en[1];
  assign m0.op_a = a16;
  assign m0.op_b = b16;
  assign m1.op_a = a_op[31:16];
  assign m1.op_b = b_op[31:16];
  assign m0.clr = mac_clr;
  assign m1.clr = mac_clr;
  assign m0.sgn = mac_sgn;
  assign m1.sgn = mac_sgn;
  assign m0.rnd = mac_rnd;
  assign m1.rnd = mac_rnd;
  assign m0.sat = mac_sat;
  assign m1.sat = mac_sat;

  mac_unit u_mac0 (
    .clk_sys (clk_sys),
    .rst (rst),
    .m (m0)
  );

  mac_unit u_mac1 (
    .clk_sys (clk_sys),
    .rst (rst),
    .m (m1)
  );

  assign acc0 = m0.acc;
  assign acc1 = m1.acc;

  //////////////////////////////////////////////////////////////////////////
  // Operation select
  always_comb begin
    alu_res = a_op;
    alu_ext = {8{alu_res[31]}};
    alu_cc = 2'h0;
    cc_upd = 1'b0;
    unique case (alu_op)
      OP_ADD: alu_res = add_w;
      OP_SUB: alu_res = sub_w;
      OP_AND: alu_res = a_op & b_op;
      OP_OR: alu_res = a_op | b_op;
      OP_XOR: alu_res = a_op ^ b_op;
      OP_NOT: alu_res = ~a_op;
      OP_DUAL: alu_res = dadd_v;
      OP_QUAD: alu_res = dadd_v;
      OP_EXTR: alu_res = extr_v;
      OP_POPC: alu_res = 32'($countones(a_op));
      OP_MUL32: alu_res = mul_v[31:0];
      OP_DIVS: alu_res = divs_v;
      OP_SAT: alu_res = {{16{sat16[15]}}, sat16};
      OP_RND: alu_res = {{16{rnd16[15]}}, rnd16};
      OP_SIGNB: alu_res = 32'(signb);
      OP_ALIGN8: alu_res = align_v;
      OP_PACK: alu_res = pack_v;
      OP_ADDC16: alu_res = clip16_v;
      OP_ADDC8: alu_res = clip8_v;
      OP_AVG8: alu_res = avg8_v;
      OP_SUB_ABS_ACC: alu_res = {rd_v[31:16] + abs_sum_hi, rd_v[15:0] + abs_sum_lo};
      OP_MIN: begin
        alu_cc = {1'b0, $signed(b_op) < $signed(a_op)};
        alu_res = alu_cc[0] ? b_op : a_op;
        cc_upd = 1'b1;
      end
      OP_MAX: begin
        alu_cc = {1'b0, $signed(b_op) > $signed(a_op)};
        alu_res = alu_cc[0] ? b_op : a_op;
        cc_upd = 1'b1;
      end
      OP_VSRCH: begin
        alu_res = vmax_v;
        alu_cc = vsel;
        cc_upd = 1'b1;
      end
      OP_SHL: begin
        alu_res = sh_l[31:0];
        alu_ext = sh_l[39:32];
      end
      OP_SHR: begin
        alu_res = sh_r[31:0];
        alu_ext = sh_r[39:32];
      end
      OP_ROT: begin
        alu_res = sh_rot[31:0];
        alu_ext = sh_rot[39:32];
      end
      OP_NORM: alu_res = a_op << signb;
      OP_DEPO: alu_res = depo_v;
      OP_MACRD0: alu_res = m0.rd;
      OP_MACRD1: alu_res = m1.rd;
      default: alu_res = a_op;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Write-back stage; half writes replicate the low result half
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_valid <= 1'b0;
      wb_dst <= 3'h0;
      wb_mask <= 2'h0;
      wb_data <= REG_RST;
      wb2_valid <= 1'b0;
      wb2_dst <= 3'h0;
      wb2_data <= REG_RST;
    end else begin
      wb_valid <= take && wr_en;
      wb_dst <= dst;
      wb_mask <= dst_mask;
      wb_data <= (dst_mask == MASK_ALL) ? alu_res : {alu_res[15:0], alu_res[15:0]};
      wb2_valid <= take && wr_en && alu_op == OP_QUAD;
      wb2_dst <= dst2;
      wb2_data <= dsub_v;
    end
  end

  // Result outputs; flags only move on compare and search operations
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      res_valid <= 1'b0;
      res <= REG_RST;
      res_ext <= 8'h00;
      cc <= 2'h0;
    end else begin
      res_valid <= take;
      if (take) begin
        res <= alu_res;
        res_ext <= alu_ext;
      end
      if (take && cc_upd) begin
        cc <= alu_cc;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address generator
  assign ag.wr_en = ag_wr_en;
  assign ag.wr_kind = ag_wr_kind;
  assign ag.wr_num = ag_wr_num;
  assign ag.wr_data = ag_wr_data;
  assign ag.gen_en = take ? ag_en : 2'h0;
  assign ag.circ = ag_circ;
  assign ag.sel[0] = ag_sel0;
  assign ag.sel[1] = ag_sel1;
  assign ag.off = imm;

  addr_gen_unit u_agu (
    .clk_sys (clk_sys),
    .rst (rst),
    .ag (ag)
  );

  assign addr0 = ag.addr[0];
  assign addr1 = ag.addr[1];
  assign addr_valid = ag.valid;
endmodule
`default_nettype wire

/* File: test/dp_properties.sv */
// Timing relations at the datapath top-level ports
`default_nettype none
module dp_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic issue,
  input wire dp_pkg::alu_op_e alu_op,
  input wire logic ld_en,
  input wire logic [1:0] mac_en,
  input wire logic mem_rvalid,
  input wire logic [1:0] ag_en,
  input wire logic stall,
  input wire logic res_valid,
  input wire logic [31:0] res,
  input wire logic [1:0] cc,
  input wire logic [39:0] acc0,
  input wire logic [1:0] addr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import dp_pkg::*;
  // A refused issue must leave no trace, so all but the two stall hold/end relations key on the taken form
  wire logic tk = issue && !stall;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_res_pulse: assert property (tk |=> res_valid) else $error("no result pulse");
  chk_res_quiet: assert property (!tk |=> !res_valid && $stable(res)) else $error("stray result");
  chk_load_stall: assert property (tk && ld_en |=> stall) else $error("load did not stall");
  chk_stall_hold: assert property (stall && !mem_rvalid |=> stall) else $error("stall dropped early");
  chk_stall_end: assert property (stall && mem_rvalid |=> !stall) else $error("stall stuck");
  chk_addr_pair: assert property (tk |=> addr_valid == $past(ag_en)) else $error("address valid wrong");
  chk_acc_hold: assert property (!(tk && mac_en[0]) |=> $stable(acc0)) else $error("acc0 moved");
  chk_cc_hold: assert property (!(tk && alu_op inside {OP_MIN, OP_MAX, OP_VSRCH}) |=> $stable(cc))
    else $error("cc moved");
endmodule
bind dual_mac_compute_datapath dp_properties u_props (.clk_sys, .rst, .issue, .alu_op, .ld_en, .mac_en,
  .mem_rvalid, .ag_en, .stall, .res_valid, .res, .cc, .acc0, .addr_valid);
`default_nettype wire

/* File: test/dp_mem_model.sv */
// Data memory port model answering loads after a chosen latency
`default_nettype none
module dp_mem_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req,
  input wire logic [3:0] lat,
  input wire logic [31:0] wdata,
  output logic rvalid,
  output logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // Data lines toggle outside the return so a stale word never looks valid
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= 4'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      cnt <= req ? lat : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
      rvalid <= cnt == 4'h1;
      rdata <= cnt == 4'h1 ? wdata : ~rdata;
    end
  end
endmodule
`default_nettype wire

/* File: test/test_dual_mac_compute_datapath.sv */
// Self-checking bench of the dual-MAC compute datapath
`default_nettype none
module test_dual_mac_compute_datapath;
  timeunit 1ns;
  timeprecision 1ps;
  import dp_pkg::*;
  logic clk_sys = 0, rst = 1, issue = 0, use_imm = 0, wr_en = 0, mac_clr = 0, mac_sgn = 0;
  logic mac_rnd = 0, mac_sat = 0, ld_en = 0, ag_wr_en = 0, mem_rvalid, stall, res_valid;
  alu_op_e alu_op = OP_ADD;
  width_e width = W32;
  ag_kind_e ag_wr_kind = AG_IDX;
  logic [3:0] src_a = 0, src_b = 0, lat = 1;
  logic [31:0] imm = 0, ag_wr_data = 0, ld_data = 0, ag_i = 0, mem_rdata, res, addr0, addr1;
  logic [2:0] dst = 0, dst2 = 0, ld_dst = 0, ag_wr_num = 0, ag_sel0 = 0, ag_sel1 = 0;
  logic [1:0] dst_mask = 2'h3, mac_en = 0, ag_en = 0, ag_circ = 0, cc, addr_valid, ccx = 0;
  logic [7:0] res_ext;
  logic [39:0] acc0, acc1, ex0 = 0, ex1 = 0;
  logic [31:0] rf [8] = '{default: 0};
  logic [31:0] agv [4] = '{32'h0000_0100, 32'h0000_0004, 32'h0000_0010, 32'h0000_0100};
  alu_op_e ops [8] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MUL32, OP_MIN, OP_MAX};
  logic [31:0] rq [$], aq [$], bq [$];
  logic [1:0] cq [$];
  int fails = 0, compares = 0;
  dual_mac_compute_datapath DUT (.clk_sys, .rst, .issue, .alu_op, .width, .src_a, .src_b, .use_imm, .imm, .wr_en,
    .dst, .dst_mask, .dst2, .mac_en, .mac_clr, .mac_sgn, .mac_rnd, .mac_sat, .ld_en, .ld_dst, .mem_rdata,
    .mem_rvalid, .ag_wr_en, .ag_wr_kind, .ag_wr_num, .ag_wr_data, .ag_en, .ag_circ, .ag_sel0, .ag_sel1, .stall,
    .res_valid, .res, .res_ext, .cc, .acc0, .acc1, .addr0, .addr1, .addr_valid);
  dp_mem_model mem (.clk_sys, .rst, .req(issue && !stall && ld_en), .lat, .wdata(ld_data), .rvalid(mem_rvalid),
    .rdata(mem_rdata));
  // Clock at 25 ns
  always #12.5 clk_sys = ~clk_sys;
  task automatic cmp32(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp40(string n, logic [39:0] e, logic [39:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Holds the issue until taken, then steps the reference model in program order
  task automatic go();
    logic [31:0] a, b, r;
    logic [15:0] a16, b16;
    logic [39:0] pa, pb;
    issue <= 1'b1;
    do @(posedge clk_sys); while (stall !== 1'b0);
    a = rf[src_a[3:1]];
    b = use_imm ? imm : rf[src_b[3:1]];
    case (alu_op)
      OP_SUB: r = a - b;
      OP_AND: r = a & b;
      OP_OR: r = a | b;
      OP_XOR: r = a ^ b;
      OP_MUL32: r = a * b;
      OP_MIN: r = ($signed(b) < $signed(a)) ? b : a;
      OP_MAX: r = ($signed(b) > $signed(a)) ? b : a;
      default: r = a + b;
    endcase
    rq.push_back(r);
    // Flags follow only compare-select; b chosen exactly when the result is not a
    if (alu_op inside {OP_MIN, OP_MAX}) ccx = {1'b0, r != a};
    cq.push_back(ccx);
    if (wr_en) rf[dst] = r;
    if (ld_en) rf[ld_dst] = ld_data;
    a16 = src_a[0] ? a[31:16] : a[15:0];
    b16 = src_b[0] ? b[31:16] : b[15:0];
    pa = mac_sgn ? {{24{a16[15]}}, a16} : {24'h00_0000, a16};
    pb = mac_sgn ? {{24{b16[15]}}, b16} : {24'h00_0000, b16};
    if (mac_en[0]) ex0 = (mac_clr ? 40'h00_0000_0000 : ex0) + pa * pb;
    pa = mac_sgn ? {{24{a[31]}}, a[31:16]} : {24'h00_0000, a[31:16]};
    pb = mac_sgn ? {{24{b[31]}}, b[31:16]} : {24'h00_0000, b[31:16]};
    if (mac_en[1]) ex1 = (mac_clr ? 40'h00_0000_0000 : ex1) + pa * pb;
    if (ag_en[1]) bq.push_back(agv[0] + imm);
    if (ag_en[0]) begin
      aq.push_back(ag_i);
      ag_i = ag_i + agv[1];
      if (ag_i >= agv[3] + agv[2]) ag_i = ag_i - agv[2];
    end
  endtask
  // Results leave in issue order; the heads were queued an edge earlier
  always @(posedge clk_sys) begin
    if (res_valid === 1'b1) cmp32("res", rq.pop_front(), res);
    if (res_valid === 1'b1) cmp32("cc", 32'(cq.pop_front()), 32'(cc));
    if (addr_valid[0] === 1'b1) cmp32("addr0", aq.pop_front(), addr0);
    if (addr_valid[1] === 1'b1) cmp32("addr1", bq.pop_front(), addr1);
  end
  // Watchdog sized well past the hundred-odd cycles of the run
  initial begin
    #20us;
    fails++;
    wrap_up();
  end
  // Main sequence: bypassed ALU chain, loads under stall, MAC run, circular addressing
  initial begin
    void'($urandom(62));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    wr_en <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      alu_op <= ops[i % 8];
      src_a <= 4'($urandom);
      src_b <= 4'($urandom);
      use_imm <= 1'($urandom);
      imm <= $urandom;
      dst <= 3'($urandom);
      dst2 <= 3'($urandom);
      ag_sel1 <= 3'($urandom);
      ag_wr_num <= 3'($urandom);
      go();
    end
    wr_en <= 1'b0;
    ag_wr_num <= 3'h0;
    for (int i = 0; i < 6; i++) begin
      ld_en <= 1'b1;
      ld_dst <= 3'(i);
      ld_data <= $urandom;
      lat <= 4'(i + 1);
      go();
      ld_en <= 1'b0;
      src_a <= {3'(i), 1'b0};
      use_imm <= 1'b1;
      imm <= 32'h0000_0000;
      alu_op <= OP_ADD;
      go();
    end
    use_imm <= 1'b0;
    mac_en <= 2'h3;
    for (int i = 0; i < 12; i++) begin
      mac_clr <= i == 0;
      mac_sgn <= 1'(i);
      src_a <= 4'($urandom);
      src_b <= 4'($urandom);
      go();
    end
    issue <= 1'b0;
    mac_en <= 2'h0;
    // Fifth write loads pointer 0 with the same word as the start index
    for (int k = 0; k < 5; k++) begin
      ag_wr_en <= 1'b1;
      ag_wr_kind <= ag_kind_e'(k);
      ag_wr_data <= agv[k % 4];
      @(posedge clk_sys);
    end
    cmp40("acc0", ex0, acc0);
    cmp40("acc1", ex1, acc1);
    ag_i = agv[0];
    ag_wr_en <= 1'b0;
    ag_en <= 2'h3;
    ag_circ <= 2'h1;
    ag_sel1 <= 3'h0;
    for (int i = 0; i < 10; i++) begin
      imm <= $urandom;
      go();
    end
    issue <= 1'b0;
    repeat (3) @(posedge clk_sys);
    wrap_up();
  end
endmodule
`default_nettype wire
